// ---- rtl/prc_rail_regs.sv ----
`timescale 1ns/1ps
`include "prc_map.svh"
// ----------------------------------------
// rail control register bank behind a serial slave port
// ----------------------------------------
module prc_rail_regs
  import prc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep_pin_n,
  input wire logic [5:1] soft_start_done,
  input wire logic [5:1] rail_good_in,
  input wire logic [5:1] ov_detect,
  input wire logic [5:1] uv_detect,
  output logic [1:0] switch_rate_select,
  output logic [6:0] rail_two_voltage_code,
  output logic [6:0] rail_three_voltage_code,
  output logic rail_one_forced_switching,
  output logic rail_four_forced_switching,
  output logic [5:1] rail_on,
  output logic [5:1] rail_keep_on,
  output logic sleep_active,
  output logic [5:1] rail_run,
  output logic [5:2] rail_drain,
  output logic [1:0] rail_one_drain_resistance,
  output logic [5:1] rail_fault_response,
  output logic mute_active,
  output logic irq_n
);

  prc_state_type state_reg;
  prc_state_type state_next;

  logic scl_s;
  logic sda_s;
  logic sleep_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [9:0] ev_pending;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  prc_pin_sync #(
    .W(3)
  ) prc_pin_sync_inst (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({scl_in, sda_in, sleep_pin_n}),
    .pin_out({scl_s, sda_s, sleep_s})
  );

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  // reserved bits are stored as zero, so a read needs no masking
  function automatic logic [7:0] reg_read(
    input prc_state_type s,
    input logic [7:0] ofs
  );
    logic [7:0] d;
    d = 8'h00;
    case (ofs)
      `PRC_OFS_RATE: d = s.rate;
      `PRC_OFS_V2: d = s.v2;
      `PRC_OFS_V3: d = s.v3;
      `PRC_OFS_MODE: d = s.mode;
      `PRC_OFS_EN: d = s.en;
      `PRC_OFS_SLEEP: d = s.sleep;
      `PRC_OFS_DIS: d = s.dis;
      `PRC_OFS_UVR: d = s.uvr;
      `PRC_OFS_MUTE: d = s.mute;
      `PRC_OFS_PG: d = s.pg; // see R14
      `PRC_OFS_OV: d = s.ov;
      `PRC_OFS_UV: d = s.uv;
      `PRC_OFS_OVM: d = s.ovm;
      `PRC_OFS_UVM: d = s.uvm;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // rail vectors sit at bits 5..1 of their register byte
  function automatic logic [7:0] rail_byte(
    input logic [5:1] v
  );
    return {2'b00, v, 1'b0};
  endfunction

  // ----------------------------------------
  // bus condition detection
  // ----------------------------------------
  // only settled samples are compared
  // scl is an input only: the slave never stretches a transfer, see R19
  assign scl_rise = scl_s & ~state_reg.scl_q;
  assign scl_fall = ~scl_s & state_reg.scl_q;
  assign bus_start = scl_s & state_reg.scl_q & state_reg.sda_q & ~sda_s;
  assign bus_stop = scl_s & state_reg.scl_q & ~state_reg.sda_q & sda_s;

  // unmasked sticky events: over-voltage high half, under-voltage low half
  // a mask only hides the line; the flag itself still latches
  assign ev_pending = {state_reg.ov[5:1] & ~state_reg.ovm[5:1],
                       state_reg.uv[5:1] & ~state_reg.uvm[5:1]};

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic [7:0] wd;
    logic [7:0] rd;
    logic do_write;
    wd = state_reg.sh;
    rd = 8'h00;
    do_write = 1'b0;
    state_next = state_reg;
    state_next.scl_q = scl_s;
    state_next.sda_q = sda_s;

    // ----------------------------------------
    // serial slave
    // ----------------------------------------
    // stop and start override any byte in progress
    if (bus_stop) begin
      state_next.st = ST_IDLE;
      state_next.sda_oe = 1'b0;
    end else if (bus_start) begin
      state_next.st = ST_ADDR;
      state_next.cnt = 4'h0;
      state_next.sda_oe = 1'b0;
    end else begin
      case (state_reg.st)
        ST_IDLE: begin
          state_next.sda_oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            state_next.sh = {state_reg.sh[6:0], sda_s};
            state_next.cnt = state_reg.cnt + 4'h1;
          end else if (scl_fall && state_reg.cnt == `PRC_BYTE_BITS) begin
            state_next.sda_oe = 1'b1; // acknowledge by pulling low
            case (state_reg.st)
              ST_ADDR: begin
                state_next.rw = state_reg.sh[0];
                if (state_reg.sh[7:1] == `PRC_SLAVE_ADDR) begin // see R18
                  state_next.st = ST_ACK_ADDR;
                end else begin
                  state_next.sda_oe = 1'b0;
                  state_next.st = ST_IDLE;
                end
              end
              ST_PTR: begin
                state_next.ptr = state_reg.sh;
                state_next.st = ST_ACK_PTR;
              end
              default: begin
                do_write = 1'b1;
                state_next.ptr = state_reg.ptr + 8'h01;
                state_next.st = ST_ACK_W;
              end
            endcase
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            state_next.cnt = 4'h0;
            if (state_reg.rw) begin
              rd = reg_read(state_reg, state_reg.ptr);
              state_next.sh = rd;
              state_next.sda_oe = ~rd[7];
              state_next.ptr = state_reg.ptr + 8'h01;
              state_next.st = ST_RDATA;
            end else begin
              state_next.sda_oe = 1'b0;
              state_next.st = ST_PTR;
            end
          end
        end
        ST_ACK_PTR, ST_ACK_W: begin
          if (scl_fall) begin
            state_next.sda_oe = 1'b0;
            state_next.cnt = 4'h0;
            state_next.st = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            state_next.cnt = state_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (state_reg.cnt == `PRC_BYTE_BITS) begin
              state_next.sda_oe = 1'b0; // let the master answer
              state_next.st = ST_RACK;
            end else begin
              state_next.sda_oe = ~state_reg.sh[3'(7 - state_reg.cnt)];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            state_next.nack = sda_s;
          end else if (scl_fall) begin
            state_next.cnt = 4'h0;
            if (state_reg.nack) begin
              state_next.st = ST_IDLE;
            end else begin
              rd = reg_read(state_reg, state_reg.ptr);
              state_next.sh = rd;
              state_next.sda_oe = ~rd[7];
              state_next.ptr = state_reg.ptr + 8'h01;
              state_next.st = ST_RDATA;
            end
          end
        end
        default: begin
          state_next.st = ST_IDLE;
          state_next.sda_oe = 1'b0;
        end
      endcase
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // reserved and read-only bits are masked off
    if (do_write) begin
      case (state_reg.ptr)
        `PRC_OFS_RATE: state_next.rate = wd & `PRC_WM_RATE; // see R1
        `PRC_OFS_V2: state_next.v2 = wd & `PRC_WM_VCODE; // see R2
        `PRC_OFS_V3: state_next.v3 = wd & `PRC_WM_VCODE; // see R3
        `PRC_OFS_MODE: state_next.mode = wd & `PRC_WM_MODE; // see R4
        `PRC_OFS_EN: state_next.en = wd & `PRC_WM_RAIL; // see R5
        `PRC_OFS_SLEEP: state_next.sleep = wd & `PRC_WM_SLEEP; // see R7
        `PRC_OFS_DIS: state_next.dis = wd & `PRC_WM_DIS; // see R10
        `PRC_OFS_UVR: state_next.uvr = wd & `PRC_WM_RAIL; // see R12
        `PRC_OFS_MUTE: state_next.mute = wd & `PRC_WM_MUTE; // see R13
        `PRC_OFS_OV: begin
          state_next.ov = state_reg.ov & ~(wd & `PRC_WM_RAIL); // see R17
        end
        `PRC_OFS_UV: begin
          state_next.uv = state_reg.uv & ~(wd & `PRC_WM_RAIL); // see R17
        end
        `PRC_OFS_OVM: state_next.ovm = wd & `PRC_WM_RAIL;
        `PRC_OFS_UVM: state_next.uvm = wd & `PRC_WM_RAIL;
        default: begin
          // unmapped and read-only offsets drop the byte, see R22
        end
      endcase
    end

    // ----------------------------------------
    // hardware events and status
    // ----------------------------------------
    // hardware events are applied after the clear so a set wins
    state_next.ov = state_next.ov | rail_byte(ov_detect); // see R15
    state_next.uv = state_next.uv | rail_byte(uv_detect); // see R16
    // a finished soft-start marks the rail enabled, see R6
    state_next.en = state_next.en | rail_byte(soft_start_done);

    // status sampled every cycle, so a read shows the live rails
    state_next.pg = rail_byte(rail_good_in); // see R14

    // ----------------------------------------
    // sleep and interrupt
    // ----------------------------------------
    // sleep source: pin is active low, software bit active high
    if (state_reg.sleep[`PRC_SLEEP_SRC_BIT]) begin // see R8
      state_next.sleep_active = state_reg.sleep[`PRC_SLEEP_SW_BIT]; // see R9
    end else begin
      state_next.sleep_active = ~sleep_s;
    end

    // in sleep only rails marked keep-on stay running, see R7
    state_next.rail_run = rail_byte(state_reg.en[5:1]
                                    & ({5{~state_reg.sleep_active}}
                                       | state_reg.sleep[6:2]));

    // interrupt line low while any unmasked flag stands, see R20
    state_next.irq_n = ~(|ev_pending); // see R21
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.rate <= `PRC_RST_RATE;
      state_reg.v2 <= `PRC_RST_V2;
      state_reg.v3 <= `PRC_RST_V3;
      state_reg.mode <= `PRC_RST_MODE;
      state_reg.en <= `PRC_RST_EN;
      state_reg.sleep <= `PRC_RST_SLEEP;
      state_reg.dis <= `PRC_RST_DIS;
      state_reg.uvr <= `PRC_RST_UVR;
      state_reg.mute <= `PRC_RST_MUTE;
      state_reg.pg <= `PRC_RST_ZERO;
      state_reg.ov <= `PRC_RST_ZERO;
      state_reg.uv <= `PRC_RST_ZERO;
      state_reg.ovm <= `PRC_RST_ZERO;
      state_reg.uvm <= `PRC_RST_ZERO;
      state_reg.sleep_active <= 1'b0;
      state_reg.rail_run <= `PRC_RST_ZERO;
      state_reg.irq_n <= 1'b1;
      state_reg.st <= ST_IDLE;
      state_reg.cnt <= 4'h0;
      state_reg.sh <= 8'h00;
      state_reg.ptr <= 8'h00;
      state_reg.rw <= 1'b0;
      state_reg.nack <= 1'b0;
      state_reg.sda_oe <= 1'b0;
      state_reg.scl_q <= 1'b1;
      state_reg.sda_q <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flip-flops except sda_out, which is tied low, and mute_active, which inverts mute bit 0
  // ----------------------------------------
  // open-drain data line: the output level is always low
  assign sda_out = 1'b0;
  assign sda_oe = state_reg.sda_oe;
  assign switch_rate_select = state_reg.rate[2:1]; // see R1
  assign rail_two_voltage_code = state_reg.v2[6:0]; // see R2
  assign rail_three_voltage_code = state_reg.v3[6:0]; // see R3
  assign rail_one_forced_switching = state_reg.mode[1]; // see R4
  assign rail_four_forced_switching = state_reg.mode[4]; // see R4
  assign rail_on = state_reg.en[5:1]; // see R5
  assign rail_keep_on = state_reg.sleep[6:2]; // see R7
  assign sleep_active = state_reg.sleep_active;
  assign rail_run = state_reg.rail_run[5:1];
  assign rail_drain = state_reg.dis[5:2]; // see R10
  assign rail_one_drain_resistance = state_reg.dis[1:0]; // see R11
  assign rail_fault_response = state_reg.uvr[5:1]; // see R12
  assign mute_active = ~state_reg.mute[0]; // see R13
  assign irq_n = state_reg.irq_n;

endmodule

// ---- rtl/prc_map.svh ----
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH
// Notes on behaviour
// R1: rate field 00..11 = 300/450/600/750kHz, resets 01
// R2: rail two code: 10mV steps from 0.7V
// R3: rail three same code, resets to 0x1E
// R4: mode bits 4 and 1: 1 forces PWM
// R5: enable bits 5..1, one per rail
// R6: soft-start completion sets the rail enable bit
// R7: keep-alive bits 6..2 hold rails in sleep
// R8: bit 0 picks sleep pin or software bit
// R9: software bit 1 enters or leaves sleep
// R10: discharge enables at bits 5..2, reset 0x1D
// R11: rail one discharge resistance two-bit field
// R12: fault response bits: 0 latch, 1 hiccup
// R13: mute bit 0: 0 mutes, resets to 1
// R14: read-only power-good bits 5..1
// R15: over-voltage condition sets sticky event flag
// R16: under-voltage condition sets sticky event flag
// R17: write one clears flag, zero leaves it
// R18: slave answers at seven-bit address 0x64
// R19: the slave never stretches the clock
// R20: mask bit 1 suppresses the matching event
// R21: interrupt low while unmasked flag is set
// R22: reserved and read-only bits ignore writes

// ----------------------------------------
// bus address
// ----------------------------------------
`define PRC_SLAVE_ADDR 7'h64

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PRC_OFS_RATE 8'h03
`define PRC_OFS_V2 8'h04
`define PRC_OFS_V3 8'h05
`define PRC_OFS_MODE 8'h06
`define PRC_OFS_EN 8'h07
`define PRC_OFS_SLEEP 8'h08
`define PRC_OFS_DIS 8'h09
`define PRC_OFS_UVR 8'h0a
`define PRC_OFS_MUTE 8'h0b
`define PRC_OFS_PG 8'h0f
`define PRC_OFS_OV 8'h10
`define PRC_OFS_UV 8'h11
`define PRC_OFS_OVM 8'h14
`define PRC_OFS_UVM 8'h15

// ----------------------------------------
// reset values
// ----------------------------------------
`define PRC_RST_RATE 8'h02
`define PRC_RST_V2 8'h32
`define PRC_RST_V3 8'h1e
`define PRC_RST_MODE 8'h00
`define PRC_RST_EN 8'h00
`define PRC_RST_SLEEP 8'h04
`define PRC_RST_DIS 8'h1d
`define PRC_RST_UVR 8'h3e
`define PRC_RST_MUTE 8'h01
`define PRC_RST_ZERO 8'h00

// ----------------------------------------
// writable bits of each register
// ----------------------------------------
`define PRC_WM_RATE 8'h06
`define PRC_WM_VCODE 8'h7f
`define PRC_WM_MODE 8'h12
`define PRC_WM_RAIL 8'h3e
`define PRC_WM_SLEEP 8'h7f
`define PRC_WM_DIS 8'h3f
`define PRC_WM_MUTE 8'h01

// ----------------------------------------
// field positions
// ----------------------------------------
`define PRC_SLEEP_SRC_BIT 0
`define PRC_SLEEP_SW_BIT 1
`define PRC_BYTE_BITS 4'h8
`endif

// ---- rtl/prc_pkg.sv ----
package prc_pkg;

  // serial slave sequencing
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
    ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
  } prc_i2c_state_type;

  // whole state of the register bank and its slave
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] v2;
    logic [7:0] v3;
    logic [7:0] mode;
    logic [7:0] en;
    logic [7:0] sleep;
    logic [7:0] dis;
    logic [7:0] uvr;
    logic [7:0] mute;
    logic [7:0] pg;
    logic [7:0] ov;
    logic [7:0] uv;
    logic [7:0] ovm;
    logic [7:0] uvm;
    logic sleep_active;
    logic [7:0] rail_run;
    logic irq_n;
    prc_i2c_state_type st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
  } prc_state_type;

endpackage

// ---- rtl/prc_pin_sync.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
module prc_pin_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } prc_sync_type;

  prc_sync_type sync_reg;
  prc_sync_type sync_next;

  // a change is accepted only once stages two and three agree,
  // which filters one-sample glitches on the bus wires
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = pin_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_reg.s2[i] == sync_reg.s3[i]) begin
        sync_next.q[i] = sync_reg.s3[i];
      end
    end
  end

  // idle bus lines and an awake sleep pin all rest high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_reg <= '1;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign pin_out = sync_reg.q;

endmodule

// ---- bench/prc_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// host bus master model
// ----------------------------------------
module prc_host_model (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  localparam int PH = 8;
  logic sda_drv = 1'b1;
  initial scl = 1'b1;
  // pull-up on the data line, device pulls low when enabled
  assign sda = sda_drv & ~sda_oe;
  task automatic tick();
    repeat (PH) @(negedge clk);
  endtask
  // start or repeated start; fixed timing, never waits on the device
  task automatic start();
    sda_drv = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b0;
    tick();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_drv = 1'b1;
    tick();
  endtask
  // drive b while low, sample the line late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
  endtask
  // msb first; the ninth bit is released, low means acknowledge
  task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(1'b1, b);
    ack = ~b;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic k1, k2, k3;
    start();
    xfer(8'hc8, r, k1);
    xfer(a, r, k2);
    xfer(d, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // pointer write, repeated start, one byte then a master nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic k1, k2, k3, k4;
    start();
    xfer(8'hc8, r, k1);
    xfer(a, r, k2);
    start();
    xfer(8'hc9, r, k3);
    xfer(8'hff, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic probe(input logic [7:0] a, output logic ok);
    logic [7:0] r;
    start();
    xfer(a, r, ok);
    stop();
  endtask
endmodule

// ---- bench/prc_rail_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the rail register bank
// ----------------------------------------
module prc_rail_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input logic sda_oe,
  input wire logic [5:1] soft_start_done,
  input logic [1:0] switch_rate_select,
  input logic [6:0] rail_two_voltage_code,
  input logic [6:0] rail_three_voltage_code,
  input logic [5:1] rail_on,
  input logic [5:1] rail_keep_on,
  input logic sleep_active,
  input logic [5:1] rail_run,
  input logic [5:2] rail_drain,
  input logic [1:0] rail_one_drain_resistance,
  input logic [5:1] rail_fault_response,
  input logic mute_active,
  input logic irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // rail gating wanted one cycle before the run outputs
  logic [5:1] run_want;
  assign run_want = rail_on & (~{5{sleep_active}} | rail_keep_on);
  AST_RST_RATE: assert property ($rose(rst_n) |->
    switch_rate_select == 2'b01) else $error("rate reset wrong");
  AST_RST_CODE: assert property ($rose(rst_n) |->
    rail_two_voltage_code == 7'h32 && rail_three_voltage_code == 7'h1e)
    else $error("voltage code reset wrong");
  AST_RST_DRAIN: assert property ($rose(rst_n) |->
    rail_drain == 4'h7 && rail_one_drain_resistance == 2'b01)
    else $error("discharge reset wrong");
  AST_RST_MISC: assert property ($rose(rst_n) |->
    rail_fault_response == 5'h1f && !mute_active && irq_n &&
    rail_keep_on == 5'h01 && rail_on == 5'h00)
    else $error("control reset wrong");
  AST_SOFT_START: assert property (soft_start_done[5] |->
    ##[1:2] rail_on[5]) else $error("soft start did not set enable");
  AST_RUN_GATE: assert property (rail_run == $past(run_want))
    else $error("rail run gating wrong");
  AST_ACK_LOW: assert property ($rose(sda_oe) |->
    !scl_in && !$past(scl_in, 3)) else $error("data driven in high");
  AST_ACK_FALL: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data released in high");
  AST_SDA_STILL: assert property (scl_in && $past(scl_in, 4) |->
    $stable(sda_oe)) else $error("data moved while clock high");
  AST_CFG_ON_LOW: assert property ($changed({switch_rate_select,
    rail_two_voltage_code, rail_three_voltage_code, rail_drain,
    rail_fault_response, mute_active}) |-> !scl_in && !$past(scl_in, 3))
    else $error("setting changed outside a write");
  COV_ACK: cover property ($rose(sda_oe));
  COV_IRQ: cover property ($fell(irq_n));
  COV_SLEEP: cover property ($rose(sleep_active));
endmodule
bind prc_rail_regs prc_rail_checker prc_rail_checker_inst (.*);

// ---- bench/test_pmic_rail_control_registers.sv ----
`timescale 1ns/1ps
module test_pmic_rail_control_registers;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_pin_n = 1'b1;
  logic [5:1] soft_start_done = '0, ov_detect = '0, uv_detect = '0;
  logic [5:1] rail_good_in = 5'h15;
  logic scl_in, sda_in, sda_out, sda_oe, ok;
  logic [5:1] rail_on, rail_keep_on, rail_run, rail_fault_response;
  logic [1:0] switch_rate_select, rail_one_drain_resistance;
  logic [6:0] rail_two_voltage_code, rail_three_voltage_code;
  logic [5:2] rail_drain;
  logic rail_one_forced_switching, rail_four_forced_switching;
  logic sleep_active, mute_active, irq_n;
  logic [7:0] rv;
  int n_mismatch = 0, n_checks = 0;
  localparam logic [7:0] OFS [12] = '{8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0f, 8'h10, 8'h0c};
  localparam logic [7:0] RST [12] = '{8'h02, 8'h32, 8'h1e, 8'h00,
    8'h00, 8'h04, 8'h1d, 8'h3e, 8'h01, 8'h2a, 8'h00, 8'h00};
  localparam logic [7:0] WMK [12] = '{8'h06, 8'h7f, 8'h7f, 8'h12,
    8'h3e, 8'h7f, 8'h3f, 8'h3e, 8'h01, 8'h2a, 8'h00, 8'h00};
  always #12.5 clk = ~clk;
  prc_rail_regs prc_rail_regs_inst (.clk(clk), .rst_n(rst_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .sleep_pin_n(sleep_pin_n), .soft_start_done(soft_start_done),
    .rail_good_in(rail_good_in), .ov_detect(ov_detect),
    .uv_detect(uv_detect), .switch_rate_select(switch_rate_select),
    .rail_two_voltage_code(rail_two_voltage_code),
    .rail_three_voltage_code(rail_three_voltage_code),
    .rail_one_forced_switching(rail_one_forced_switching),
    .rail_four_forced_switching(rail_four_forced_switching),
    .rail_on(rail_on), .rail_keep_on(rail_keep_on),
    .sleep_active(sleep_active), .rail_run(rail_run),
    .rail_drain(rail_drain),
    .rail_one_drain_resistance(rail_one_drain_resistance),
    .rail_fault_response(rail_fault_response), .mute_active(mute_active),
    .irq_n(irq_n));
  prc_host_model prc_host_model_inst (.clk(clk), .sda_oe(sda_oe),
    .scl(scl_in), .sda(sda_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    prc_host_model_inst.wr(a, d, ok);
    check({7'h00, ok}, 8'h01);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    prc_host_model_inst.rd(a, rv, ok);
    check({7'h00, ok}, 8'h01);
    check(rv, exp);
  endtask
  // one-cycle pulse, given at the falling edge
  task automatic pulse(ref logic [5:1] s, input logic [5:1] v);
    s = v;
    @(negedge clk);
    s = '0;
    repeat (2) @(negedge clk);
  endtask
  // hang guard; the run needs well under this many cycles
  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    foreach (OFS[i]) rd_chk(OFS[i], RST[i]);
    foreach (OFS[i]) wr(OFS[i], 8'hff);
    foreach (OFS[i]) rd_chk(OFS[i], WMK[i]);
    check({1'b0, rail_three_voltage_code}, 8'h7f);
    check({rail_drain, 4'h0}, 8'hf0);
    check({rail_keep_on, sleep_active, sda_out, 1'b0}, 8'hfc);
    check({rail_on, 3'h0}, 8'hf8);
    check({rail_run, 3'h0}, 8'hf8);
    check({rail_fault_response, 3'h0}, 8'hf8);
    check({switch_rate_select, rail_one_forced_switching,
      rail_four_forced_switching, rail_one_drain_resistance,
      mute_active, 1'b0}, 8'hfc);
    foreach (OFS[i]) wr(OFS[i], 8'h00);
    check({switch_rate_select, rail_one_forced_switching,
      rail_four_forced_switching, rail_one_drain_resistance,
      mute_active, 1'b0}, 8'h02);
    check({rail_drain, rail_fault_response[5:2]}, 8'h00);
    check({rail_keep_on, sleep_active, rail_on[2:1]}, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, 8'(c * 2));
      check(8'(switch_rate_select), 8'(c));
    end
    wr(8'h04, 8'h50);
    check({1'b0, rail_two_voltage_code}, 8'h50);
    // sleep from the pin, rail one kept alive
    wr(8'h07, 8'h3e);
    wr(8'h08, 8'h04);
    sleep_pin_n = 1'b0;
    repeat (8) @(negedge clk);
    check({2'b00, sleep_active, rail_run}, 8'h21);
    wr(8'h08, 8'h05);
    check({2'b00, sleep_active, rail_run}, 8'h1f);
    wr(8'h08, 8'h07);
    check({2'b00, sleep_active, rail_run}, 8'h21);
    wr(8'h08, 8'h05);
    check({2'b00, sleep_active, rail_run}, 8'h1f);
    sleep_pin_n = 1'b1;
    // soft start completion sets enables
    wr(8'h07, 8'h00);
    pulse(soft_start_done, 5'h14);
    rd_chk(8'h07, 8'h28);
    // over-voltage event, cleared only by a one
    pulse(ov_detect, 5'h02);
    check({7'h00, irq_n}, 8'h00);
    rd_chk(8'h10, 8'h04);
    wr(8'h10, 8'h00);
    rd_chk(8'h10, 8'h04);
    wr(8'h10, 8'h04);
    rd_chk(8'h10, 8'h00);
    check({7'h00, irq_n}, 8'h01);
    // masked under-voltage event keeps the interrupt quiet
    wr(8'h15, 8'h20);
    pulse(uv_detect, 5'h10);
    check({7'h00, irq_n}, 8'h01);
    rd_chk(8'h11, 8'h20);
    wr(8'h11, 8'h20);
    rd_chk(8'h11, 8'h00);
    prc_host_model_inst.probe(8'hca, ok);
    check({7'h00, ok}, 8'h00);
    summarize();
  end
endmodule
